// *** shared/eprd_defs.svh ***
// Constants for the EPROM read/program host controller.
// Assumes a 20 MHz system clock and one attached 16K x 8 EPROM.
`ifndef EPRD_DEFS_SVH
`define EPRD_DEFS_SVH

`define EPRD_CLK_MHZ        20
`define EPRD_T_ACC_NS       300
`define EPRD_T_CE_NS        300
`define EPRD_T_OE_NS        110
`define EPRD_T_DF_NS        80
`define EPRD_T_PULSE_US     1000
`define EPRD_CYC(ns)        ((((ns) * `EPRD_CLK_MHZ) + 999) / 1000)
`define EPRD_ACC_CYC        (`EPRD_CYC(`EPRD_T_ACC_NS) + 2)
`define EPRD_GATE_LAG_CYC   `EPRD_CYC(`EPRD_T_CE_NS - `EPRD_T_OE_NS)
`define EPRD_OE_CYC         (`EPRD_CYC(`EPRD_T_OE_NS) + 2)
`define EPRD_DF_CYC         (`EPRD_CYC(`EPRD_T_DF_NS) + 1)
`define EPRD_PULSE_CYC      ((`EPRD_T_PULSE_US * `EPRD_CLK_MHZ))
`define EPRD_ADDR_W         14
`define EPRD_CNT_W          16
`define EPRD_ID_LSB_BIT     0

`endif

// *** shared/eprd_pkg.sv ***
// Types for the EPROM host controller.
// Assumes eprd_defs.svh is on the include path.
`include "eprd_defs.svh"
package eprd_pkg;
   typedef enum logic [2:0] {
      EPRD_OP_READ,
      EPRD_OP_VERIFY,
      EPRD_OP_ID,
      EPRD_OP_PROGRAM
   } eprd_op_e;

   typedef struct packed {
      eprd_op_e                  op;
      logic [`EPRD_ADDR_W-1:0]   addr;
      logic [7:0]                data;
   } eprd_req_s;

   typedef struct packed {
      logic       chip_sel_low;
      logic       out_gate_low;
      logic       program_strobe_low;
      logic       vpp_high;
      logic       high_voltage_level;
   } eprd_ctl_s;
endpackage

// *** hw/eprd_host.sv ***
// Host controller that reads, verifies, identifies and programs one EPROM.
// Assumes the EPROM pins are wired directly; supply switches are external.
`timescale 1ns/1ns
`default_nettype none
`include "eprd_defs.svh"
module eprd_host #(
   parameter int PULSE_CYC = `EPRD_PULSE_CYC
) (
   // Clock and reset
   input  wire logic                    clk_sys_in,
   input  wire logic                    reset_in,
   // Request side
   input  wire logic                    req_valid_in,
   input  wire eprd_pkg::eprd_req_s     req_in,
   output var  logic                    req_ready_out,
   output var  logic                    rsp_valid_out,
   output var  logic [7:0]              rsp_data_out,
   output var  logic                    rsp_parity_ok_out,
   // EPROM pins
   output var  eprd_pkg::eprd_ctl_s     ctl_out,
   output var  logic [`EPRD_ADDR_W-1:0] addr_out,
   input  wire logic [7:0]              data_outputs_in,
   output var  logic [7:0]              data_outputs_out,
   output var  logic                    data_outputs_oe_out
);
   import eprd_pkg::*;

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      EPRD_IDLE, EPRD_SETUP, EPRD_GATE, EPRD_SAMPLE, EPRD_PULSE, EPRD_FLOAT
   } eprd_state_e;

   eprd_state_e               state_r, state_nxt;
   logic [`EPRD_CNT_W-1:0]    cnt_r, cnt_nxt;
   eprd_req_s                 req_r;
   eprd_req_s                 act_req;
   eprd_ctl_s                 ctl_nxt;
   logic [7:0]                sync1_r, sync2_r;
   logic                      cnt_done;
   logic                      is_prog;
   logic                      take_req;
   logic                      sample_now;
   logic                      busy_nxt;
   logic                      sel_nxt;
   logic                      gate_nxt;
   logic                      strobe_nxt;
   logic                      vpp_nxt;
   logic                      hv_nxt;
   logic                      oe_nxt;
   logic                      rsp_nxt;
   logic [`EPRD_ADDR_W-1:0]   addr_nxt;

   function automatic logic odd_parity(input logic [7:0] b);
      odd_parity = ^b;
   endfunction

   // ----------------------------------------------------------------
   // Request decode
   // ----------------------------------------------------------------
   // Ready is registered, so nothing is taken before it is shown
   assign take_req   = (state_r == EPRD_IDLE) && req_valid_in &&
                       req_ready_out;

   // Pins follow the new request on the very edge that takes it
   assign act_req    = (state_r == EPRD_IDLE) ? req_in : req_r;
   assign cnt_done   = (cnt_r == '0);
   assign is_prog    = (act_req.op == EPRD_OP_PROGRAM);
   assign sample_now = (state_r == EPRD_SAMPLE);

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      state_nxt = state_r;
      cnt_nxt   = cnt_done ? cnt_r : cnt_r - 1'b1;
      unique case (state_r)
         EPRD_IDLE: begin
            if (take_req) begin
               state_nxt = EPRD_SETUP;
               cnt_nxt   = `EPRD_CNT_W'(`EPRD_GATE_LAG_CYC);
            end
         end
         // gate lag: select leads gate by select minus gate time
         EPRD_SETUP: begin
            if (cnt_done) begin
               state_nxt = is_prog ? EPRD_PULSE : EPRD_GATE;
               cnt_nxt   = is_prog ? `EPRD_CNT_W'(PULSE_CYC - 1)
                                   : `EPRD_CNT_W'(`EPRD_OE_CYC);
            end
         end
         // access wait: gate delay after select lead
         EPRD_GATE: begin
            if (cnt_done) begin
               state_nxt = EPRD_SAMPLE;
            end
         end
         EPRD_SAMPLE: begin
            state_nxt = EPRD_FLOAT;
            cnt_nxt   = `EPRD_CNT_W'(`EPRD_DF_CYC);
         end
         EPRD_PULSE: begin
            if (cnt_done) begin
               state_nxt = EPRD_FLOAT;
               cnt_nxt   = `EPRD_CNT_W'(`EPRD_DF_CYC);
            end
         end
         EPRD_FLOAT: begin
            if (cnt_done) begin
               state_nxt = EPRD_IDLE;
            end
         end
         default: state_nxt = EPRD_IDLE;
      endcase
   end

   // ----------------------------------------------------------------
   // Pin drive
   // ----------------------------------------------------------------
   // select choice: select held for whole access, gate only gates
   assign busy_nxt   = (state_nxt != EPRD_IDLE);
   assign sel_nxt    = busy_nxt && (state_nxt != EPRD_FLOAT);
   // gating: gate low only in the access wait and the sample of a read, verify or id
   assign gate_nxt   = (state_nxt == EPRD_GATE) ||
                       (state_nxt == EPRD_SAMPLE);
   // program pulse: strobe low only during the pulse
   assign strobe_nxt = (state_nxt == EPRD_PULSE);
   // supply level: raised for verify and program only
   // Supply stays up through the float wait, so it drops after select
   assign vpp_nxt    = busy_nxt &&
                       ((act_req.op == EPRD_OP_VERIFY) || is_prog);
   // id voltage: forced only for identifier reads
   assign hv_nxt     = busy_nxt && (act_req.op == EPRD_OP_ID);

   // One word of pin levels, registered as a whole
   assign ctl_nxt    = '{chip_sel_low:       sel_nxt,
                         out_gate_low:       gate_nxt,
                         program_strobe_low: strobe_nxt,
                         vpp_high:           vpp_nxt,
                         high_voltage_level: hv_nxt};

   // id address: all lines low except the byte select
   assign addr_nxt   = (act_req.op == EPRD_OP_ID) ?
                       {{(`EPRD_ADDR_W-1){1'b0}},
                        act_req.addr[`EPRD_ID_LSB_BIT]} : act_req.addr;

   // drive data only in programming, never while gated
   assign oe_nxt     = is_prog && sel_nxt;
   assign rsp_nxt    = sample_now ||
                       ((state_r == EPRD_PULSE) && cnt_done);

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   // Data pins run on no clock of ours, so two stages before use
   always_ff @(posedge clk_sys_in) begin
      sync1_r <= data_outputs_in;
      sync2_r <= sync1_r;
   end

   always_ff @(posedge clk_sys_in) begin
      if (reset_in) begin
         state_r <= EPRD_IDLE;
         cnt_r   <= '0;
      end else begin
         state_r <= state_nxt;
         cnt_r   <= cnt_nxt;
      end
   end

   // Request is latched only on the edge that takes it
   always_ff @(posedge clk_sys_in) begin
      if (reset_in) begin
         req_r <= '0;
      end else if (take_req) begin
         req_r <= req_in;
      end
   end

   // ----------------------------------------------------------------
   // Pin outputs
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys_in) begin
      if (reset_in) begin
         ctl_out             <= '0;
         addr_out            <= '0;
         data_outputs_out    <= '0;
         data_outputs_oe_out <= 1'b0;
      end else begin
         ctl_out             <= ctl_nxt;
         addr_out            <= addr_nxt;
         data_outputs_out    <= act_req.data;
         data_outputs_oe_out <= oe_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Answer
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys_in) begin
      if (reset_in) begin
         req_ready_out <= 1'b0;
         rsp_valid_out <= 1'b0;
      end else begin
         req_ready_out <= !busy_nxt;
         rsp_valid_out <= rsp_nxt;
      end
   end

   // Byte and parity hold until the next sampled byte
   always_ff @(posedge clk_sys_in) begin
      if (reset_in) begin
         rsp_data_out      <= '0;
         rsp_parity_ok_out <= 1'b0;
      end else if (sample_now) begin
         rsp_data_out      <= sync2_r;
         // byte parity: odd parity over all eight bits of every sampled byte
         rsp_parity_ok_out <= odd_parity(sync2_r);
      end
   end
endmodule
`default_nettype wire

// *** dv/eprd_host_assertions.sv ***
// Pin and answer checks for the EPROM host controller.
// Bound to eprd_host; sees only its ports.
`timescale 1ns/1ns
`default_nettype none
module eprd_host_assertions #(
   parameter int PULSE_CYC = 8
) (
   input wire logic                clk_sys_in,
   input wire logic                reset_in,
   input wire logic                req_valid_in,
   input wire eprd_pkg::eprd_req_s req_in,
   input wire logic                req_ready_out,
   input wire logic                rsp_valid_out,
   input wire logic [7:0]          rsp_data_out,
   input wire logic                rsp_parity_ok_out,
   input wire eprd_pkg::eprd_ctl_s ctl_out,
   input wire logic [13:0]         addr_out,
   input wire logic [7:0]          data_outputs_in,
   input wire logic [7:0]          data_outputs_out,
   input wire logic                data_outputs_oe_out
);
   import eprd_pkg::*;
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (reset_in);
   sequence gate_held; ctl_out.out_gate_low [*5]; endsequence
   sequence taken;
      req_valid_in && req_ready_out && req_in.op != EPRD_OP_PROGRAM;
   endsequence
   AST_GATE_NEEDS_SEL: assert property (ctl_out.out_gate_low |->
      ctl_out.chip_sel_low) else $error("gate without select");
   AST_SEL_SETTLED: assert property ($rose(ctl_out.out_gate_low) |->
      $past(ctl_out.chip_sel_low, 4)) else $error("gate too early");
   AST_GATE_HOLD: assert property ($rose(ctl_out.out_gate_low) |->
      gate_held) else $error("gate too short");
   AST_NO_CONTEND: assert property (data_outputs_oe_out |->
      !ctl_out.out_gate_low && ctl_out.vpp_high) else $error("contention");
   AST_STROBE_MODE: assert property (ctl_out.program_strobe_low |->
      ctl_out.vpp_high && ctl_out.chip_sel_low) else $error("bad strobe");
   AST_ID_ADDR: assert property (ctl_out.high_voltage_level |->
      addr_out[13:1] == 13'h0) else $error("id address high");
   AST_PARITY: assert property (rsp_valid_out |->
      rsp_parity_ok_out == ^rsp_data_out) else $error("parity flag");
   AST_IDLE_STANDBY: assert property (req_ready_out |->
      !ctl_out.chip_sel_low && !ctl_out.vpp_high) else $error("idle busy");
   AST_ANSWER: assert property (taken |-> ##[8:30] rsp_valid_out)
      else $error("no answer");
   // Pulse length is counted, too long for a repetition
   int unsigned strobe_len_r = 0;
   always_ff @(posedge clk_sys_in)
      strobe_len_r <= ctl_out.program_strobe_low ? strobe_len_r + 1 : 0;
   AST_PULSE_LEN: assert property ($fell(ctl_out.program_strobe_low) |->
      strobe_len_r == PULSE_CYC) else $error("pulse length");
endmodule
bind eprd_host eprd_host_assertions #(.PULSE_CYC(PULSE_CYC)) u_chk (
   .clk_sys_in(clk_sys_in), .reset_in(reset_in),
   .req_valid_in(req_valid_in), .req_in(req_in),
   .req_ready_out(req_ready_out), .rsp_valid_out(rsp_valid_out),
   .rsp_data_out(rsp_data_out), .rsp_parity_ok_out(rsp_parity_ok_out),
   .ctl_out(ctl_out), .addr_out(addr_out),
   .data_outputs_in(data_outputs_in), .data_outputs_out(data_outputs_out),
   .data_outputs_oe_out(data_outputs_oe_out));
`default_nettype wire

// *** dv/eprd_eprom_model.sv ***
// Behavioural 16K x 8 EPROM facing the host controller.
// Assumes the bench resolves the shared data pins.
`timescale 1ns/1ns
`default_nettype none
module eprd_eprom_model #(
   parameter logic [7:0] MFR_ID = 8'h07, // Arbitrary value
   parameter logic [7:0] DEV_ID = 8'h83  // Arbitrary value
) (
   // Pins
   input  wire eprd_pkg::eprd_ctl_s ctl_in,
   input  wire logic [13:0]         addr_in,
   input  wire logic [7:0]          pins_in,
   output var  logic [7:0]          drive_out,
   output var  logic                drive_en_out
);
   import eprd_pkg::*;
   logic [7:0] mem [0:16383];
   logic       rd_en;
   logic       rd_en_dly;
   logic [7:0] rd_val;
   logic [7:0] last_r = 8'h00;
   initial for (int i = 0; i < 16384; i++) mem[i] = 8'(i) ^ 8'hA5;
   assign rd_en = ctl_in.chip_sel_low && ctl_in.out_gate_low &&
      !ctl_in.program_strobe_low;
   assign #110 rd_en_dly = rd_en;
   assign rd_val = ctl_in.high_voltage_level ?
      (addr_in[0] ? DEV_ID : MFR_ID) : mem[addr_in];
   assign drive_en_out = rd_en && rd_en_dly;
   // Floated pins show the inverse so stale samples get caught
   assign drive_out = drive_en_out ? rd_val : ~last_r;
   always @(negedge drive_en_out) last_r = rd_val;
   always @(posedge ctl_in.program_strobe_low)
      if (ctl_in.vpp_high && ctl_in.chip_sel_low)
         mem[addr_in] = mem[addr_in] & pins_in;
endmodule
`default_nettype wire

// *** dv/eprd_host_tb.sv ***
// Self-checking bench for the EPROM host controller.
// Assumes the model and checker files are compiled first.
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin bad_count++; \
   $display("MISMATCH %0t got %h exp %h", $time, g, e); end end
module eprd_host_tb;
   import eprd_pkg::*;
   localparam logic [7:0] MFR = 8'h07; // Arbitrary value
   localparam logic [7:0] DEV = 8'h83; // Arbitrary value
   logic        clk_sys_in = 0, reset_in = 1, req_valid_in = 0;
   logic        req_ready_out, rsp_valid_out, rsp_parity_ok_out, oe, drv_en;
   eprd_req_s   req_in = '0;
   eprd_ctl_s   ctl_out;
   logic [13:0] addr_out;
   logic [7:0]  rsp_data_out, d_in, d_out, drv, got;
   int          bad_count = 0, compares = 0;
   assign d_in = oe ? d_out : drv;
   eprd_host #(.PULSE_CYC(8)) DUT (.clk_sys_in(clk_sys_in),
      .reset_in(reset_in), .req_valid_in(req_valid_in), .req_in(req_in),
      .req_ready_out(req_ready_out), .rsp_valid_out(rsp_valid_out),
      .rsp_data_out(rsp_data_out), .rsp_parity_ok_out(rsp_parity_ok_out),
      .ctl_out(ctl_out), .addr_out(addr_out), .data_outputs_in(d_in),
      .data_outputs_out(d_out), .data_outputs_oe_out(oe));
   eprd_eprom_model #(.MFR_ID(MFR), .DEV_ID(DEV)) u_rom (.ctl_in(ctl_out),
      .addr_in(addr_out), .pins_in(d_in), .drive_out(drv),
      .drive_en_out(drv_en));
   initial forever #25 clk_sys_in = ~clk_sys_in;
   // Model must stay quiet whenever the host drives the data pins
   always @(negedge clk_sys_in) if (oe === 1'b1) `CHK(drv_en, 1'b0)
   task automatic give_verdict;
      $display("compares %0d mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic step(inout int n);
      @(posedge clk_sys_in);
      #1;
      n++;
      if (n > 200) begin
         bad_count++;
         give_verdict();
      end
   endtask
   task automatic xfer(input eprd_op_e op, input logic [13:0] a,
                       input logic [7:0] d);
      int n;
      n = 0;
      req_in = '{op, a, d};
      req_valid_in = 1;
      while (req_ready_out !== 1'b1) step(n);
      step(n);
      req_valid_in = 0;
      while (rsp_valid_out !== 1'b1) step(n);
      got = rsp_data_out;
   endtask
   task automatic t_read;
      xfer(EPRD_OP_READ, 14'h0000, 8'h00);
      `CHK(got, 8'hA5)
      `CHK(rsp_parity_ok_out, 1'b0)
      xfer(EPRD_OP_READ, 14'h3FFF, 8'h00);
      `CHK(got, 8'h5A)
      $display("read test done");
   endtask
   task automatic t_id;
      xfer(EPRD_OP_ID, 14'h3FFE, 8'h00);
      `CHK(got, MFR)
      `CHK(rsp_parity_ok_out, 1'b1)
      xfer(EPRD_OP_ID, 14'h0001, 8'h00);
      `CHK(got, DEV)
      `CHK(rsp_parity_ok_out, 1'b1)
      $display("id test done");
   endtask
   task automatic t_prog;
      xfer(EPRD_OP_PROGRAM, 14'h0005, 8'h3C);
      xfer(EPRD_OP_VERIFY, 14'h0005, 8'h00);
      `CHK(got, 8'h20)
      xfer(EPRD_OP_READ, 14'h0006, 8'h00);
      `CHK(got, 8'hA3)
      $display("program test done");
   endtask
   initial begin
      repeat (5) @(posedge clk_sys_in);
      #1;
      reset_in = 0;
      t_read();
      t_id();
      t_prog();
      give_verdict();
   end
endmodule
`default_nettype wire
